// *** ast_pkg.sv ***
// async serial transceiver: register map, field layout, states, helpers
// assumes a 32-bit AHB-Lite register bus and one 50 MHz clock
`default_nettype none
package ast_pkg;
  // ********************************************************
  // register offsets (byte addresses)
  // ********************************************************
  localparam logic [7:0] OFS_TX_DATA = 8'h00;
  localparam logic [7:0] OFS_RX_DATA = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_EN = 8'h10;
  localparam logic [7:0] OFS_GLOBAL = 8'h14;
  localparam logic [7:0] OFS_CHAR_CFG = 8'h18;
  localparam logic [7:0] OFS_BAUD = 8'h1c;
  // ********************************************************
  // field positions
  // ********************************************************
  localparam int GC_GLOBAL = 0;
  localparam int GC_RX = 1;
  localparam int GC_TX = 2;
  localparam int CC_PEN = 0;
  localparam int CC_ODD = 1;
  localparam int CC_STOP = 2;
  localparam int CC_BREAK = 4;
  localparam int CC_CHAR = 5;
  localparam int CC_FLOW = 7;
  localparam int CC_BRK11 = 8;
  localparam int FL_TXE = 0;
  localparam int FL_TXC = 1;
  localparam int FL_OVR = 2;
  localparam int FL_RBRK = 3;
  localparam int FL_PERR = 4;
  localparam int FL_RXV = 5;
  localparam int BR_INT = 4;
  // ********************************************************
  // reset values and counts
  // ********************************************************
  localparam logic [2:0] GC_RST = 3'h0;
  localparam logic [8:0] CC_RST = 9'h060;
  localparam logic [19:0] BR_RST = 20'h00010;
  localparam logic [5:0] IEN_RST = 6'h00;
  localparam logic [4:0] FL_RST = 5'h03;
  localparam logic [5:0] BIT_LAST = 6'h0f;
  localparam logic [3:0] SAMP_A = 4'h7;
  localparam logic [3:0] SAMP_C = 4'h9;
  localparam logic [3:0] SAMP_END = 4'hf;
  localparam logic [3:0] BRK_LAST10 = 4'h9;
  localparam logic [3:0] BRK_LAST11 = 4'ha;
  localparam logic [5:0] RX_DEPTH = 6'h20;
  localparam logic [5:0] STOP_1 = 6'h0f;
  localparam logic [5:0] STOP_H = 6'h07;
  localparam logic [5:0] STOP_2 = 6'h1f;
  localparam logic [5:0] STOP_1H = 6'h17;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BRK, TX_MARK
  } ast_tx_t;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_WAIT
  } ast_rx_t;

  // last tick index of the stop period: 1, 0.5, 2, 1.5 bits
  function automatic logic [5:0] stop_last(input logic [1:0] stop_bit_count);
    stop_last = (stop_bit_count == 2'h0) ? STOP_1 : (stop_bit_count == 2'h1) ? STOP_H :
                (stop_bit_count == 2'h2) ? STOP_2 : STOP_1H;
  endfunction
  function automatic logic [3:0] char_last(input logic [1:0] ch);
    char_last = {2'h1, ch};
  endfunction
  function automatic logic [7:0] char_mask(input logic [1:0] ch);
    char_mask = 8'hff >> (2'h3 - ch);
  endfunction
  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
  endfunction
endpackage
`default_nettype wire

// *** ast_baud.sv ***
// fractional oversample tick generator, one tick per 1/16 bit
// assumes the divisor is stable while run is high
`default_nettype none
module ast_baud
  import ast_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic [15:0] div_int,
  input wire logic [3:0] div_frac,
  output logic tick
);
  logic [15:0] cnt_r;
  logic [3:0] acc_r;
  logic extra_r;
  logic [16:0] lim;
  logic [4:0] acc_sum;
  logic wrap;

  // a period of div_int cycles, one longer whenever the fraction carries
  assign lim = (div_int == 16'h0000) ? 17'h00000 :
               {1'b0, div_int} - 17'h00001 + {16'h0000, extra_r};
  assign wrap = ({1'b0, cnt_r} >= lim);
  assign acc_sum = {1'b0, acc_r} + {1'b0, div_frac};
  // not registered: a registered tick would stretch the first bit of
  // every frame by one clock
  assign tick = run && wrap;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 16'h0000;
      acc_r <= 4'h0;
      extra_r <= 1'b0;
    end else if (!run) begin
      cnt_r <= 16'h0000;
      acc_r <= 4'h0;
      extra_r <= 1'b0;
    end else if (wrap) begin
      cnt_r <= 16'h0000;
      acc_r <= acc_sum[3:0];
      extra_r <= acc_sum[4];
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// *** ast_top.sv ***
// async serial transceiver: AHB-Lite slave, transmitter, receiver
// assumes one clock, a free serial line and software keeping enables set
//
// Overview of operation
// - frame: low start, 5 to 8 data bits LSB first, high stop bits
// - stop length selectable: half, one, one and a half or two bits
// - optional odd or even parity bit between data and stop bits
// - one fractional divisor, 16.4 bits, feeds both sides while enabled
// - idle enabled transmitter drives high; disabled releases the pin
// - in flow mode a high clear-to-send holds off the next character
// - in flow mode request-to-send low means ready to receive
// - idle character is a whole frame of ones before the next data
// - a frame of zeros received sets the receive break flag
// - sent break is 10 or 11 low bits then the stop bits
// - send-break waits for current character, self-clears, high bit after
// - write during sending waits in holding register until frame end
// - write while idle starts at once and marks the holding empty
// - transmit-empty set on move to shifter, cleared by a data write
// - transmission-complete set after data or idle frame stop bits with nothing waiting
// - enabled receiver hunts a start bit, shifts data LSB first
// - receive bits are oversampled so noise is told from data
// - finished character goes to receive data, sets receive-valid
// - character into full buffer sets overrun, keeps older data
// - one byte of transmit buffer and 32 bytes of receive buffer
`default_nettype none
module ast_top
  import ast_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_in,
  output logic tx_out,
  output logic tx_oe,
  input wire logic clear_to_send_n,
  output logic request_to_send_n,
  output logic irq_req
);
  // ********************************************************
  // registers and bus slave
  // ********************************************************
  logic [2:0] gcr_r;
  logic [8:0] ccr_r;
  logic [19:0] brr_r;
  logic [5:0] ien_r;
  logic [4:0] flg_r;
  logic [4:0] flg_nxt;
  logic [4:0] fl_set;
  logic [4:0] fl_clr;
  logic wr_pend_r;
  logic [7:0] wr_ofs_r;
  logic acc, rd_acc;
  logic we_tx, we_fl, we_ie, we_gc, we_cc, we_br;
  logic [31:0] rd_val;
  logic tx_on, rx_on, pen, podd, flow, brk11, brk_req;
  logic [1:0] stop_bit_count, chr;

  assign tx_on = gcr_r[GC_GLOBAL] & gcr_r[GC_TX];
  assign rx_on = gcr_r[GC_GLOBAL] & gcr_r[GC_RX];
  assign pen = ccr_r[CC_PEN];
  assign podd = ccr_r[CC_ODD];
  assign stop_bit_count = ccr_r[CC_STOP +: 2];
  assign chr = ccr_r[CC_CHAR +: 2];
  assign flow = ccr_r[CC_FLOW];
  assign brk11 = ccr_r[CC_BRK11];
  assign brk_req = ccr_r[CC_BREAK];

  // only whole-word transfers are taken; others complete and do nothing
  assign acc = hsel & hready & htrans[1] & (hsize == 3'b010);
  assign rd_acc = acc & ~hwrite;
  assign we_tx = wr_pend_r && (wr_ofs_r == OFS_TX_DATA);
  assign we_fl = wr_pend_r && (wr_ofs_r == OFS_FLAGS);
  assign we_ie = wr_pend_r && (wr_ofs_r == OFS_IRQ_EN);
  assign we_gc = wr_pend_r && (wr_ofs_r == OFS_GLOBAL);
  assign we_cc = wr_pend_r && (wr_ofs_r == OFS_CHAR_CFG);
  assign we_br = wr_pend_r && (wr_ofs_r == OFS_BAUD);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      wr_pend_r <= acc & hwrite;
      wr_ofs_r <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rd_acc) begin
        hrdata <= rd_val;
      end
    end
  end

  // tx-data write also clears transmit-empty and transmit-complete
  assign fl_clr = (we_fl ? hwdata[4:0] : 5'h00) |
                  (we_tx ? 5'h03 : 5'h00);
  assign flg_nxt = (flg_r & ~fl_clr) | fl_set;

  logic brk_clr;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gcr_r <= GC_RST;
      ccr_r <= CC_RST;
      brr_r <= BR_RST;
      ien_r <= IEN_RST;
      flg_r <= FL_RST;
    end else begin
      flg_r <= flg_nxt;
      if (we_gc) gcr_r <= hwdata[2:0];
      if (we_br) brr_r <= hwdata[19:0];
      if (we_ie) ien_r <= hwdata[5:0];
      if (we_cc) begin
        ccr_r <= hwdata[8:0];
      end else if (brk_clr) begin
        ccr_r[CC_BREAK] <= 1'b0;
      end
    end
  end

  // ********************************************************
  // pin synchronisers
  // ********************************************************
  logic rx_s1, rx_s2, rx_s3, rx_line_r;
  logic cts_s1, cts_s2, cts_s3, cts_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {rx_s1, rx_s2, rx_s3, rx_line_r} <= 4'hf;
      {cts_s1, cts_s2, cts_s3, cts_r} <= 4'h0;
    end else begin
      {rx_s1, rx_s2, rx_s3} <= {rx_in, rx_s1, rx_s2};
      {cts_s1, cts_s2, cts_s3} <= {clear_to_send_n, cts_s1, cts_s2};
      if (rx_s2 == rx_s3) rx_line_r <= rx_s3;
      if (cts_s2 == cts_s3) cts_r <= cts_s3;
    end
  end

  // ********************************************************
  // transmitter
  // ********************************************************
  ast_tx_t tx_st;
  logic [5:0] tcnt_r;
  logic [3:0] tbit_r, brk_last;
  logic [7:0] tsh_r, hold_r, tmask;
  logic tpar_r, idle_fr_r, brk_fr_r, hold_full_r, idle_pend_r, tx_on_d_r;
  logic tx_tick, bit_end, tx_stop_done, tx_line, cts_block, tx_ok;
  logic tx_load, tx_brk_go, tx_idle_go, tx_done_empty;

  ast_baud u_tx_baud (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(tx_on && (tx_st != TX_IDLE)),
    .div_int(brr_r[BR_INT +: 16]),
    .div_frac(brr_r[3:0]),
    .tick(tx_tick)
  );

  assign tmask = char_mask(chr);
  assign brk_last = brk11 ? BRK_LAST11 : BRK_LAST10;
  assign bit_end = tx_tick && (tcnt_r == BIT_LAST) && (tx_st != TX_STOP);
  assign tx_stop_done = (tx_st == TX_STOP) && tx_tick &&
                        (tcnt_r == stop_last(stop_bit_count));
  assign cts_block = flow & cts_r;
  assign tx_ok = tx_on && (tx_st == TX_IDLE) && !cts_block;
  assign tx_idle_go = tx_ok && idle_pend_r;
  assign tx_brk_go = tx_ok && !idle_pend_r && brk_req;
  assign tx_load = tx_ok && !idle_pend_r && !brk_req &&
                   hold_full_r;
  assign tx_done_empty = tx_stop_done && !brk_fr_r &&
                         !hold_full_r;
  assign brk_clr = (tx_st == TX_BRK) && bit_end && (tbit_r == brk_last);
  assign tx_line = !tx_on ? 1'b1 :
                   (tx_st == TX_BRK) ? 1'b0 :
                   idle_fr_r ? 1'b1 :
                   (tx_st == TX_START) ? 1'b0 :
                   (tx_st == TX_DATA) ? tsh_r[0] :
                   (tx_st == TX_PAR) ? tpar_r : 1'b1;

  // one-byte holding register in front of the shifter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_r <= 8'h00;
      hold_full_r <= 1'b0;
    end else if (we_tx) begin
      hold_r <= hwdata[7:0];
      hold_full_r <= 1'b1;
    end else if (tx_load) begin
      hold_full_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_on_d_r <= 1'b0;
      idle_pend_r <= 1'b0;
      tx_out <= 1'b1;
      tx_oe <= 1'b0;
    end else begin
      tx_on_d_r <= tx_on;
      if (!tx_on || tx_idle_go) idle_pend_r <= 1'b0;
      else if (!tx_on_d_r) idle_pend_r <= 1'b1;
      tx_out <= tx_line;
      tx_oe <= tx_on;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st <= TX_IDLE;
      tcnt_r <= 6'h00;
      tbit_r <= 4'h0;
      tsh_r <= 8'h00;
      tpar_r <= 1'b0;
      idle_fr_r <= 1'b0;
      brk_fr_r <= 1'b0;
    end else if (!tx_on) begin
      // dropping the enable mid-frame loses that character
      tx_st <= TX_IDLE;
      tcnt_r <= 6'h00;
      idle_fr_r <= 1'b0;
      brk_fr_r <= 1'b0;
    end else begin
      if (tx_tick) begin
        tcnt_r <= (bit_end || tx_stop_done) ? 6'h00 : tcnt_r + 6'h01;
      end
      case (tx_st)
        TX_IDLE: begin
          tbit_r <= 4'h0;
          if (tx_idle_go) begin
            tx_st <= TX_START;
            idle_fr_r <= 1'b1;
          end else if (tx_brk_go) begin
            tx_st <= TX_BRK;
          end else if (tx_load) begin
            tx_st <= TX_START;
            tsh_r <= hold_r & tmask;
            tpar_r <= ^(hold_r & tmask) ^ podd;
          end
        end
        TX_START: if (bit_end) tx_st <= TX_DATA;
        TX_DATA: begin
          if (bit_end) begin
            tsh_r <= {1'b0, tsh_r[7:1]};
            tbit_r <= tbit_r + 4'h1;
            if (tbit_r == char_last(chr)) tx_st <= pen ? TX_PAR : TX_STOP;
          end
        end
        TX_PAR: if (bit_end) tx_st <= TX_STOP;
        TX_STOP: begin
          if (tx_stop_done) begin
            tx_st <= brk_fr_r ? TX_MARK : TX_IDLE;
            brk_fr_r <= 1'b0;
            idle_fr_r <= 1'b0;
          end
        end
        TX_BRK: begin
          if (bit_end) begin
            tbit_r <= tbit_r + 4'h1;
            if (tbit_r == brk_last) begin
              tx_st <= TX_STOP;
              brk_fr_r <= 1'b1;
            end
          end
        end
        TX_MARK: if (bit_end) tx_st <= TX_IDLE;
        default: tx_st <= TX_IDLE;
      endcase
    end
  end

  // ********************************************************
  // receiver
  // ********************************************************
  ast_rx_t rx_st;
  logic [3:0] rcnt_r, rbit_r;
  logic [2:0] rsamp_r;
  logic [7:0] rsh_r, rx_word;
  logic rpar_r, rzero_r, rx_tick, r_mid, r_end, rv_now, rv;
  logic rx_good, rx_brk, rx_push, rx_ovr, rx_perr, rd_pop;
  logic [7:0] rx_mem [RX_DEPTH];
  logic [4:0] rx_wp_r, rx_rp_r;
  logic [5:0] rx_cnt_r;
  logic rx_ne, rx_full;

  ast_baud u_rx_baud (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(rx_on && (rx_st != RX_IDLE) && (rx_st != RX_WAIT)),
    .div_int(brr_r[BR_INT +: 16]),
    .div_frac(brr_r[3:0]),
    .tick(rx_tick)
  );

  // three samples at ticks 7, 8, 9 of each bit decide it by majority
  assign r_mid = rx_tick && (rcnt_r == SAMP_C);
  assign r_end = rx_tick && (rcnt_r == SAMP_END);
  assign rv_now = maj3({rsamp_r[1:0], rx_line_r});
  assign rv = maj3(rsamp_r);
  assign rx_word = rsh_r >> (2'h3 - chr);
  assign rx_good = (rx_st == RX_STOP) && r_mid && rv_now;
  // zeros through the stop sample make a break, never a character
  assign rx_brk = (rx_st == RX_STOP) && r_mid && !rv_now && rzero_r;
  assign rx_ne = (rx_cnt_r != 6'h00);
  assign rx_full = (rx_cnt_r == RX_DEPTH);
  assign rx_push = rx_good && !rx_full;
  assign rx_ovr = rx_good && rx_full;
  assign rx_perr = rx_good && pen && (^rx_word ^ rpar_r ^ podd);
  assign rd_pop = rd_acc && (haddr[7:0] == OFS_RX_DATA) && rx_ne;
  assign fl_set = {rx_perr, rx_brk, rx_ovr, tx_done_empty,
                   tx_load};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st <= RX_IDLE;
      rcnt_r <= 4'h0;
      rbit_r <= 4'h0;
      rsamp_r <= 3'h7;
      rsh_r <= 8'h00;
      rpar_r <= 1'b0;
      rzero_r <= 1'b0;
    end else if (!rx_on) begin
      rx_st <= RX_IDLE;
      rcnt_r <= 4'h0;
    end else begin
      if (rx_tick) rcnt_r <= rcnt_r + 4'h1;
      if (rx_tick && (rcnt_r >= SAMP_A) && (rcnt_r <= SAMP_C)) begin
        rsamp_r <= {rsamp_r[1:0], rx_line_r};
      end
      case (rx_st)
        RX_IDLE: begin
          rcnt_r <= 4'h0;
          rbit_r <= 4'h0;
          rzero_r <= 1'b1;
          if (!rx_line_r) rx_st <= RX_START;
        end
        RX_START: begin
          if (r_mid && rv_now) rx_st <= RX_IDLE;
          else if (r_end) rx_st <= RX_DATA;
        end
        RX_DATA: begin
          if (r_end) begin
            rsh_r <= {rv, rsh_r[7:1]};
            rzero_r <= rzero_r & ~rv;
            rbit_r <= rbit_r + 4'h1;
            if (rbit_r == char_last(chr)) rx_st <= pen ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: begin
          if (r_end) begin
            rpar_r <= rv;
            rzero_r <= rzero_r & ~rv;
            rx_st <= RX_STOP;
          end
        end
        RX_STOP: if (r_mid) rx_st <= rv_now ? RX_IDLE : RX_WAIT;
        RX_WAIT: if (rx_line_r) rx_st <= RX_IDLE;
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // 32-byte receive buffer; a full buffer drops the new character
  always_ff @(posedge hclk) begin
    if (rx_push) rx_mem[rx_wp_r] <= rx_word;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_wp_r <= 5'h00;
      rx_rp_r <= 5'h00;
      rx_cnt_r <= 6'h00;
    end else begin
      if (rx_push) rx_wp_r <= rx_wp_r + 5'h01;
      if (rd_pop) rx_rp_r <= rx_rp_r + 5'h01;
      rx_cnt_r <= rx_cnt_r + {5'h00, rx_push} - {5'h00, rd_pop};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      request_to_send_n <= 1'b1;
      irq_req <= 1'b0;
    end else begin
      request_to_send_n <= !(flow && rx_on && !rx_full);
      irq_req <= |({rx_ne, flg_r} & ien_r);
    end
  end

  always_comb begin
    rd_val = 32'h00000000;
    if (haddr[7:0] == OFS_RX_DATA) begin
      rd_val = rx_ne ? {24'h000000, rx_mem[rx_rp_r]} : 32'h00000000;
    end else if (haddr[7:0] == OFS_STATUS) begin
      rd_val = {27'h0000000, rx_full, (tx_st != TX_IDLE), !hold_full_r,
                rx_ne, flg_r[FL_TXC]};
    end else if (haddr[7:0] == OFS_FLAGS) begin
      rd_val = {26'h0000000, rx_ne, flg_r};
    end else if (haddr[7:0] == OFS_IRQ_EN) begin
      rd_val = {26'h0000000, ien_r};
    end else if (haddr[7:0] == OFS_GLOBAL) begin
      rd_val = {29'h00000000, gcr_r};
    end else if (haddr[7:0] == OFS_CHAR_CFG) begin
      rd_val = {23'h000000, ccr_r};
    end else if (haddr[7:0] == OFS_BAUD) begin
      rd_val = {12'h000, brr_r};
    end
  end

  // ********************************************************
  // checks
  // ********************************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_idle_high: assert property (
    $past(tx_on && tx_st == TX_IDLE) |-> tx_out)
    else $error("idle transmitter not high");
  a_off_release: assert property (!tx_on |=> !tx_oe)
    else $error("pin still driven while disabled");
  a_start_low: assert property ($past(tx_on && tx_st == TX_START &&
    !idle_fr_r) |-> !tx_out)
    else $error("start bit not low");
  a_data_lsb: assert property ($past(tx_on && tx_st == TX_DATA &&
    !idle_fr_r) |-> tx_out == $past(tsh_r[0]))
    else $error("data bit not lsb of shifter");
  a_par_bit: assert property ($past(tx_on && tx_st == TX_PAR &&
    !idle_fr_r) |-> tx_out == $past(tpar_r))
    else $error("parity bit wrong");
  a_cts_hold: assert property (tx_st == TX_IDLE && tx_on && cts_block
    |=> tx_st == TX_IDLE)
    else $error("started while clear-to-send high");
  a_rts_ready: assert property (flow && rx_on && !rx_full
    |=> !request_to_send_n)
    else $error("request-to-send not low when ready");
  a_temp_set: assert property (tx_load |=> flg_r[FL_TXE] &&
    tx_st == TX_START)
    else $error("transmit-empty not set on load");
  a_temp_clr: assert property (we_tx && !tx_load |=> !flg_r[FL_TXE])
    else $error("transmit-empty not cleared by write");
  a_txc_set: assert property (tx_done_empty |=> flg_r[FL_TXC])
    else $error("complete flag missing");
  a_brk_bits: assert property (tx_st == TX_BRK |->
    tbit_r <= brk_last)
    else $error("break too long");
  a_brk_clear: assert property (brk_clr && !we_cc |=> !brk_req &&
    tx_st == TX_STOP)
    else $error("send-break not cleared in stop");
  a_ovr_keep: assert property (rx_ovr && !rd_pop |=> flg_r[FL_OVR] &&
    rx_cnt_r == $past(rx_cnt_r))
    else $error("overrun lost older data");
  a_rx_brk: assert property (rx_brk && !rd_pop |=> flg_r[FL_RBRK] &&
    rx_cnt_r == $past(rx_cnt_r))
    else $error("break flag missing or pushed");
  a_false_start: assert property (rx_st == RX_START && r_mid &&
    rv_now |=> rx_st == RX_IDLE)
    else $error("false start not dropped");
  a_rx_push: assert property (rx_push |=> rx_ne)
    else $error("received byte not stored");

  c_tx_frame: cover property (tx_done_empty);
  c_rx_byte: cover property (rx_push);
  c_tx_break: cover property (brk_clr);
  c_overrun: cover property (rx_ovr);
endmodule
`default_nettype wire

// *** ast_line.sv ***
// far-side serial equipment: sends frames to rx, captures frames from tx
// assumes baud integer 1, so one bit lasts 16 clocks
`default_nettype none
module ast_line (
  input wire logic hclk,
  input wire logic tx_line,
  output logic rx_line,
  output logic cts_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************************************
  // line model
  // ********************************************************
  localparam int BP = 16;
  initial begin
    rx_line = 1'h1;
    cts_n = 1'h0; // does not pause the device until pause is called
  end
  // the remote side raises clear-to-send to pause the device
  task automatic pause(input logic p);
    cts_n <= p;
  endtask
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0}; // start low, lsb first, stop high
    for (int i = 0; i < 10; i++) begin
      @(posedge hclk);
      rx_line <= f[i];
      repeat (BP - 1) @(posedge hclk);
    end
  endtask
  // a missing or broken frame returns x so the caller's compare fails
  task automatic grab(output logic [7:0] b);
    int n;
    n = 0;
    b = 8'hxx;
    while (tx_line !== 1'h0 && n < 2000) begin
      @(posedge hclk);
      n++;
    end
    if (n < 2000) begin
      repeat (BP / 2) @(posedge hclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BP) @(posedge hclk);
        b[i] = tx_line;
      end
      repeat (BP) @(posedge hclk);
      if (tx_line !== 1'h1) b = 8'hxx; // stop bit high
    end
  endtask
endmodule
`default_nettype wire

// *** tb_async_serial_transceiver.sv ***
// testbench: bus tasks, scenario tasks and the verdict
// assumes ast_top answers with zero wait states, ast_line on the pins
`default_nettype none
module tb_async_serial_transceiver;
  import ast_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************************************
  // bench
  // ********************************************************
  logic hclk = 1'h0, hresetn = 1'h0, hwrite = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_v;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, rx_in, tx_out, tx_oe, cts_n, rts_n, irq_req;
  int n_mismatch = 0, check_count = 0;
  ast_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_in(rx_in), .tx_out(tx_out),
    .tx_oe(tx_oe), .clear_to_send_n(cts_n), .request_to_send_n(rts_n),
    .irq_req(irq_req));
  ast_line line_u (.hclk(hclk), .tx_line(tx_out), .rx_line(rx_in),
    .cts_n(cts_n));
  initial forever #10 hclk = ~hclk;
  task automatic report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic hw;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'h1 && n < 50) begin
      @(posedge hclk);
      n++;
    end
    if (n == 50) begin
      n_mismatch++;
      report_and_stop;
    end
  endtask
  // entered just after a rising edge; read data lands in rd_v
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hw;
    htrans <= 2'h0;
    hwdata <= d;
    hw;
    rd_v = hrdata;
  endtask
  task automatic t_regs;
    bus(1'h0, OFS_FLAGS, 32'h0);
    chk(rd_v, 32'h3);
    bus(1'h0, OFS_CHAR_CFG, 32'h0);
    chk(rd_v, 32'h60);
    bus(1'h0, 8'h40, 32'h0);
    chk(rd_v, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    chk({31'h0, rts_n}, 32'h1);
  endtask
  task automatic t_tx;
    logic [7:0] b0, b1;
    bus(1'h1, OFS_GLOBAL, 32'h7); // enables stay set all run
    repeat (2) @(posedge hclk);
    chk({31'h0, tx_oe}, 32'h1);
    // let the idle frame pass so the first byte loads the shifter
    repeat (200) @(posedge hclk);
    fork
      begin
        bus(1'h1, OFS_TX_DATA, 32'h5a);
        bus(1'h1, OFS_TX_DATA, 32'hc3);
      end
      begin
        line_u.grab(b0);
        line_u.grab(b1);
      end
    join
    chk({24'h0, b0}, 32'h5a);
    chk({24'h0, b1}, 32'hc3);
    repeat (16) @(posedge hclk);
    bus(1'h0, OFS_FLAGS, 32'h0);
    chk(rd_v & 32'h3, 32'h3);
  endtask
  task automatic t_rx;
    bus(1'h1, OFS_IRQ_EN, 32'h20);
    line_u.send(8'h3c);
    repeat (20) @(posedge hclk);
    chk({31'h0, irq_req}, 32'h1);
    bus(1'h0, OFS_STATUS, 32'h0);
    chk(rd_v & 32'h2, 32'h2);
    bus(1'h0, OFS_RX_DATA, 32'h0);
    chk(rd_v, 32'h3c);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq_req}, 32'h0);
  endtask
  task automatic t_brk;
    int n;
    n = 0;
    bus(1'h1, OFS_CHAR_CFG, 32'h70);
    while (tx_out !== 1'h0 && n < 500) begin
      @(posedge hclk);
      n++;
    end
    n = 0;
    while (tx_out === 1'h0 && n < 500) begin
      @(posedge hclk);
      n++;
    end
    chk(n, 32'ha0);
    bus(1'h0, OFS_CHAR_CFG, 32'h0);
    chk(rd_v, 32'h60);
  endtask
  // flow mode: a paused device holds a written byte until released
  task automatic t_flow;
    logic [7:0] b;
    line_u.pause(1'h1);
    bus(1'h1, OFS_CHAR_CFG, 32'he0);
    repeat (2) @(posedge hclk);
    chk({31'h0, rts_n}, 32'h0);
    bus(1'h1, OFS_TX_DATA, 32'h96);
    repeat (60) @(posedge hclk);
    bus(1'h0, OFS_STATUS, 32'h0);
    chk(rd_v, 32'h0);
    chk({31'h0, tx_out}, 32'h1);
    line_u.pause(1'h0);
    line_u.grab(b);
    chk({24'h0, b}, 32'h96);
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_regs;
    t_tx;
    t_rx;
    t_brk;
    t_flow;
    report_and_stop;
  end
endmodule
`default_nettype wire
